//--- rtl/core_multicycle_sequencer.sv
// multicycle sequencer for fetch, data and coprocessor sides of the core
`timescale 1ns/1ps
module core_multicycle_sequencer #(
	parameter int AW = 32,
	parameter int DW = 32
) (
	input wire logic clk,
	input wire logic sys_rst,
	// register port
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// operation request
	input wire logic op_start,
	input wire seq_pkg::op_t op_code,
	input wire logic [AW-1:0] op_data_addr,
	input wire logic [AW-1:0] op_fetch_addr,
	input wire logic [AW-1:0] op_vector,
	input wire logic [seq_pkg::MODE_W-1:0] op_new_mode,
	input wire logic [1:0] op_ret_kind,
	input wire logic [AW-1:0] op_cur_fetch_data_bus_addr,
	input wire logic [AW-1:0] op_next_fetch_data_bus_addr,
	input wire logic [DW-1:0] op_store_data0,
	input wire logic [DW-1:0] op_store_data1,
	input wire logic [1:0] op_interlock,
	input wire logic op_byte,
	input wire logic irq,
	// memory answers
	input wire logic [DW-1:0] read_data,
	input wire logic data_abort,
	// coprocessor handshakes
	input wire logic [1:0] coproc_decode_handshake,
	input wire logic [1:0] coproc_execute_handshake,
	// fetch side
	output logic [AW-1:0] fetch_address_bus,
	output logic fetch_request_n,
	output logic fetch_sequential,
	output logic privileged_access_n,
	output logic compressed_state_flag,
	// data side
	output logic [AW-1:0] data_address_bus,
	output logic data_request_n,
	output logic data_sequential,
	output logic data_write,
	output logic data_byte,
	output logic [DW-1:0] write_data,
	output logic bus_lock_out,
	output logic speculative_access_n,
	// coprocessor side
	output logic coproc_pass,
	output logic late_abort_cancel,
	// register file side
	output logic dest_wr_en,
	output logic [DW-1:0] dest_wr_data,
	output logic link_wr_en,
	output logic [AW-1:0] link_wr_data,
	output logic busy,
	output logic done,
	output logic refused,
	output logic abandoned
);
	import seq_pkg::*;

	state_t state_ff, nxt_state;
	logic [AW-1:0] da_ff, nxt_da;
	logic [AW-1:0] fb_ff, nxt_fb;
	logic [AW-1:0] vec_ff, nxt_vec;
	logic [AW-1:0] ret_ff, nxt_ret;
	logic [DW-1:0] wd1_ff, nxt_wd1;
	logic [DW-1:0] rd_ff, nxt_rd;
	logic [1:0] ilk_ff, nxt_ilk;
	logic abt_ff, nxt_abt;
	logic ctrl_cmp_ff, nxt_ctrl_cmp;
	logic swap_abort_ff, nxt_swap_abort;
	logic refused_st_ff, nxt_refused_st;
	logic [31:0] cur_sr_ff, nxt_cur_sr;
	logic [31:0] saved_sr_ff, nxt_saved_sr;
	logic [31:0] rdata_ff, nxt_rdata;

	logic [AW-1:0] fa_ff, nxt_fa;
	logic freq_n_ff, nxt_freq_n;
	logic fseq_ff, nxt_fseq;
	logic priv_n_ff, nxt_priv_n;
	logic cmp_out_ff, nxt_cmp_out;
	logic [AW-1:0] dab_ff, nxt_dab;
	logic dreq_n_ff, nxt_dreq_n;
	logic data_sequential_ff, nxt_data_sequential;
	logic dwr_ff, nxt_dwr;
	logic dbyte_ff, nxt_dbyte;
	logic [DW-1:0] wdat_ff, nxt_wdat;
	logic lock_ff, nxt_lock;
	logic spec_n_ff, nxt_spec_n;
	logic pass_ff, nxt_pass;
	logic lc_ff, nxt_lc;
	logic dwe_ff, nxt_dwe;
	logic [DW-1:0] dwd_ff, nxt_dwd;
	logic lwe_ff, nxt_lwe;
	logic [AW-1:0] lwd_ff, nxt_lwd;
	logic done_ff, nxt_done;
	logic ref_ff, nxt_ref;
	logic abn_ff, nxt_abn;

	always_comb begin
		nxt_state = state_ff;
		nxt_da = da_ff;
		nxt_fb = fb_ff;
		nxt_vec = vec_ff;
		nxt_ret = ret_ff;
		nxt_wd1 = wd1_ff;
		nxt_rd = rd_ff;
		nxt_ilk = ilk_ff;
		nxt_abt = abt_ff;
		nxt_ctrl_cmp = ctrl_cmp_ff;
		nxt_swap_abort = swap_abort_ff;
		nxt_refused_st = refused_st_ff;
		nxt_cur_sr = cur_sr_ff;
		nxt_saved_sr = saved_sr_ff;
		nxt_rdata = 32'h0000_0000;
		// default cycle: both sides idle
		nxt_fa = fa_ff;
		nxt_freq_n = 1'b1;
		nxt_fseq = 1'b0;
		nxt_priv_n = priv_n_ff;
		nxt_dab = dab_ff;
		nxt_dreq_n = 1'b1;
		nxt_data_sequential = 1'b0;
		nxt_dwr = 1'b0;
		nxt_dbyte = 1'b0;
		nxt_wdat = wdat_ff;
		nxt_lock = 1'b0;
		nxt_spec_n = 1'b1;
		nxt_pass = 1'b0;
		nxt_lc = 1'b0;
		nxt_dwe = 1'b0;
		nxt_dwd = dwd_ff;
		nxt_lwe = 1'b0;
		nxt_lwd = lwd_ff;
		nxt_done = 1'b0;
		nxt_ref = 1'b0;
		nxt_abn = 1'b0;

		if (reg_wr) begin
			if (reg_addr == REG_CTRL) begin
				nxt_ctrl_cmp = reg_wdata[CTRL_COMPRESSED];
			end else if (reg_addr == REG_STATUS) begin
				// write one to clear the sticky flags
				if (reg_wdata[STAT_SWAP_ABORT]) nxt_swap_abort = 1'b0;
				if (reg_wdata[STAT_REFUSED]) nxt_refused_st = 1'b0;
			end else if (reg_addr == REG_CUR_SR) begin
				nxt_cur_sr = reg_wdata;
			end
		end
		if (reg_rd) begin
			if (reg_addr == REG_CTRL) begin
				nxt_rdata[CTRL_COMPRESSED] = ctrl_cmp_ff;
			end else if (reg_addr == REG_STATUS) begin
				nxt_rdata[STAT_BUSY] = (state_ff != st_idle);
				nxt_rdata[STAT_SWAP_ABORT] = swap_abort_ff;
				nxt_rdata[STAT_REFUSED] = refused_st_ff;
			end else if (reg_addr == REG_CUR_SR) begin
				nxt_rdata = cur_sr_ff;
			end else if (reg_addr == REG_SAVED_SR) begin
				nxt_rdata = saved_sr_ff;
			end
		end

		case (state_ff)
			st_idle: begin
				if (op_start) begin
					nxt_da = op_data_addr;
					nxt_fb = op_fetch_addr;
					nxt_wd1 = op_store_data1;
					nxt_ilk = op_interlock;
					nxt_abt = 1'b0;
					nxt_fa = op_fetch_addr;
					case (op_code)
						op_store_double: begin
							// first cycle of a two-register store-multiple
							nxt_state = st_sd1;
							nxt_dab = op_data_addr;
							nxt_dreq_n = 1'b0;
							nxt_dwr = 1'b1;
							nxt_wdat = op_store_data0;
						end
						op_swap: begin
							if (ctrl_cmp_ff) begin
								nxt_ref = 1'b1;
								nxt_refused_st = 1'b1;
							end else begin
								nxt_state = st_sw1;
								nxt_dab = op_data_addr;
								nxt_dreq_n = 1'b0;
								nxt_dbyte = op_byte;
								nxt_lock = 1'b1;
								nxt_wdat = op_store_data0;
							end
						end
						op_preload: begin
							// single cycle, nothing to wait on
							nxt_freq_n = 1'b0;
							nxt_fseq = 1'b1;
							nxt_dab = op_data_addr;
							nxt_spec_n = 1'b0;
							nxt_done = 1'b1;
						end
						op_exception: begin
							nxt_state = st_ex1;
							nxt_vec = op_vector;
							nxt_fa = op_vector;
							nxt_freq_n = 1'b0;
							nxt_priv_n = 1'b1;
							nxt_cur_sr[MODE_LSB +: MODE_W] = op_new_mode;
							nxt_ctrl_cmp = 1'b0;
							if (op_ret_kind == RET_IRQ || op_ret_kind == RET_DABT) begin
								nxt_ret = op_next_fetch_data_bus_addr;
							end else begin
								nxt_ret = op_cur_fetch_data_bus_addr;
							end
						end
						op_coproc: begin
							// decode handshake comes with the request
							if (ctrl_cmp_ff || coproc_decode_handshake == HS_ABSENT) begin
								nxt_ref = 1'b1;
								nxt_refused_st = 1'b1;
							end else begin
								nxt_pass = 1'b1;
								if (coproc_decode_handshake == HS_WAIT) begin
									nxt_state = st_cp_wait;
								end else begin
									nxt_freq_n = 1'b0;
									nxt_fseq = 1'b1;
									nxt_done = 1'b1;
								end
							end
						end
						default: begin
							nxt_ref = 1'b1;
						end
					endcase
				end
			end
			st_sd1: begin
				nxt_state = st_sd2;
				nxt_freq_n = 1'b0;
				nxt_fseq = 1'b1;
				nxt_dab = da_ff + WORD_STEP;
				nxt_dreq_n = 1'b0;
				nxt_data_sequential = 1'b1;
				nxt_dwr = 1'b1;
			end
			st_sd2: begin
				// second word leaves in the overlapped cycle
				nxt_state = st_idle;
				nxt_wdat = wd1_ff;
				nxt_done = 1'b1;
			end
			st_sw1: begin
				nxt_state = st_sw2;
				nxt_dab = da_ff;
				nxt_dreq_n = 1'b0;
				nxt_dwr = 1'b1;
				nxt_dbyte = dbyte_ff;
				nxt_lock = 1'b1;
				if (ilk_ff == 2'h0) begin
					nxt_freq_n = 1'b0;
					nxt_fseq = 1'b1;
				end
			end
			st_sw2: begin
				// read data lands in the second cycle
				nxt_state = st_sw3;
				nxt_rd = dbyte_ff ? {{(DW-8){1'b0}}, read_data[7:0]} : read_data;
				nxt_abt = data_abort;
				if (ilk_ff == 2'h1) begin
					nxt_freq_n = 1'b0;
					nxt_fseq = 1'b1;
				end
			end
			st_sw3: begin
				// write data goes out overlapping the next instruction
				if (ilk_ff == 2'h2) begin
					nxt_state = st_sw4;
					nxt_freq_n = 1'b0;
					nxt_fseq = 1'b1;
				end else begin
					nxt_state = st_idle;
					nxt_done = 1'b1;
				end
				nxt_dwe = !(abt_ff || data_abort);
				nxt_dwd = rd_ff;
				// built on the cleared value so a same-cycle clear only loses to a real abort
				nxt_swap_abort = nxt_swap_abort || abt_ff || data_abort;
			end
			st_sw4: begin
				nxt_state = st_idle;
				nxt_done = 1'b1;
			end
			st_ex1: begin
				nxt_state = st_ex2;
				nxt_fa = vec_ff + WORD_STEP;
				nxt_freq_n = 1'b0;
				nxt_fseq = 1'b1;
				nxt_lwe = 1'b1;
				nxt_lwd = ret_ff;
				nxt_saved_sr = cur_sr_ff;
			end
			st_ex2: begin
				nxt_state = st_ex3;
				nxt_fa = vec_ff + VEC_STEP2;
				nxt_freq_n = 1'b0;
				nxt_fseq = 1'b1;
			end
			st_ex3: begin
				// fetched words in entry are not checked on abort entry
				nxt_state = st_idle;
				nxt_done = 1'b1;
			end
			st_cp_wait: begin
				nxt_pass = 1'b1;
				if (irq) begin
					nxt_state = st_idle;
					nxt_pass = 1'b0;
					nxt_abn = 1'b1;
				end else if (coproc_execute_handshake == HS_LAST ||
					coproc_execute_handshake == HS_GO) begin
					nxt_state = st_idle;
					nxt_freq_n = 1'b0;
					nxt_fseq = 1'b1;
					nxt_done = 1'b1;
				end
			end
			default: begin
				nxt_state = st_idle;
			end
		endcase

		// entry always lands in the full-width state
		nxt_cmp_out = (nxt_state inside {st_ex1, st_ex2, st_ex3}) ? 1'b0 : nxt_ctrl_cmp;
		if (nxt_state == st_idle && state_ff != st_ex3 && state_ff != st_ex2 &&
			state_ff != st_ex1) begin
			nxt_priv_n = priv_n_ff;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_ff <= st_idle;
			da_ff <= '0;
			fb_ff <= '0;
			vec_ff <= '0;
			ret_ff <= '0;
			wd1_ff <= '0;
			rd_ff <= '0;
			ilk_ff <= 2'h0;
			abt_ff <= 1'b0;
			ctrl_cmp_ff <= 1'b0;
			swap_abort_ff <= 1'b0;
			refused_st_ff <= 1'b0;
			cur_sr_ff <= CUR_SR_RESET;
			saved_sr_ff <= SAVED_SR_RESET;
			rdata_ff <= 32'h0000_0000;
			fa_ff <= '0;
			freq_n_ff <= 1'b1;
			fseq_ff <= 1'b0;
			priv_n_ff <= 1'b1;
			cmp_out_ff <= 1'b0;
			dab_ff <= '0;
			dreq_n_ff <= 1'b1;
			data_sequential_ff <= 1'b0;
			dwr_ff <= 1'b0;
			dbyte_ff <= 1'b0;
			wdat_ff <= '0;
			lock_ff <= 1'b0;
			spec_n_ff <= 1'b1;
			pass_ff <= 1'b0;
			lc_ff <= 1'b0;
			dwe_ff <= 1'b0;
			dwd_ff <= '0;
			lwe_ff <= 1'b0;
			lwd_ff <= '0;
			done_ff <= 1'b0;
			ref_ff <= 1'b0;
			abn_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			da_ff <= nxt_da;
			fb_ff <= nxt_fb;
			vec_ff <= nxt_vec;
			ret_ff <= nxt_ret;
			wd1_ff <= nxt_wd1;
			rd_ff <= nxt_rd;
			ilk_ff <= nxt_ilk;
			abt_ff <= nxt_abt;
			ctrl_cmp_ff <= nxt_ctrl_cmp;
			swap_abort_ff <= nxt_swap_abort;
			refused_st_ff <= nxt_refused_st;
			cur_sr_ff <= nxt_cur_sr;
			saved_sr_ff <= nxt_saved_sr;
			rdata_ff <= nxt_rdata;
			fa_ff <= nxt_fa;
			freq_n_ff <= nxt_freq_n;
			fseq_ff <= nxt_fseq;
			priv_n_ff <= nxt_priv_n;
			cmp_out_ff <= nxt_cmp_out;
			dab_ff <= nxt_dab;
			dreq_n_ff <= nxt_dreq_n;
			data_sequential_ff <= nxt_data_sequential;
			dwr_ff <= nxt_dwr;
			dbyte_ff <= nxt_dbyte;
			wdat_ff <= nxt_wdat;
			lock_ff <= nxt_lock;
			spec_n_ff <= nxt_spec_n;
			pass_ff <= nxt_pass;
			lc_ff <= nxt_lc;
			dwe_ff <= nxt_dwe;
			dwd_ff <= nxt_dwd;
			lwe_ff <= nxt_lwe;
			lwd_ff <= nxt_lwd;
			done_ff <= nxt_done;
			ref_ff <= nxt_ref;
			abn_ff <= nxt_abn;
		end
	end

	assign reg_rdata = rdata_ff;
	assign fetch_address_bus = fa_ff;
	assign fetch_request_n = freq_n_ff;
	assign fetch_sequential = fseq_ff;
	assign privileged_access_n = priv_n_ff;
	assign compressed_state_flag = cmp_out_ff;
	assign data_address_bus = dab_ff;
	assign data_request_n = dreq_n_ff;
	assign data_sequential = data_sequential_ff;
	assign data_write = dwr_ff;
	assign data_byte = dbyte_ff;
	assign write_data = wdat_ff;
	assign bus_lock_out = lock_ff;
	assign speculative_access_n = spec_n_ff;
	assign coproc_pass = pass_ff;
	assign late_abort_cancel = lc_ff;
	assign dest_wr_en = dwe_ff;
	assign dest_wr_data = dwd_ff;
	assign link_wr_en = lwe_ff;
	assign link_wr_data = lwd_ff;
	assign busy = (state_ff != st_idle);
	assign done = done_ff;
	assign refused = ref_ff;
	assign abandoned = abn_ff;
endmodule : core_multicycle_sequencer

//--- rtl/seq_pkg.sv
// constants, codes and register map of the multicycle sequencer
package seq_pkg;
	typedef enum logic [2:0] {
		op_store_double,
		op_swap,
		op_preload,
		op_exception,
		op_coproc
	} op_t;

	typedef enum {
		st_idle,
		st_sd1,
		st_sd2,
		st_sw1,
		st_sw2,
		st_sw3,
		st_sw4,
		st_ex1,
		st_ex2,
		st_ex3,
		st_cp_wait
	} state_t;

	// coprocessor handshake codes
	localparam logic [1:0] HS_ABSENT = 2'h0;
	localparam logic [1:0] HS_WAIT = 2'h1;
	localparam logic [1:0] HS_GO = 2'h2;
	localparam logic [1:0] HS_LAST = 2'h3;

	// return address basis for exception entry
	localparam logic [1:0] RET_TRAP = 2'h0;
	localparam logic [1:0] RET_IRQ = 2'h1;
	localparam logic [1:0] RET_PABT = 2'h2;
	localparam logic [1:0] RET_DABT = 2'h3;

	localparam logic [31:0] WORD_STEP = 32'h0000_0004;
	localparam logic [31:0] VEC_STEP2 = 32'h0000_0008;

	// register map, byte addresses
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_CUR_SR = 4'h8;
	localparam logic [3:0] REG_SAVED_SR = 4'hC;

	localparam int CTRL_COMPRESSED = 0;
	localparam int STAT_BUSY = 0;
	localparam int STAT_SWAP_ABORT = 1;
	localparam int STAT_REFUSED = 2;
	localparam int MODE_LSB = 0;
	localparam int MODE_W = 5;

	localparam logic [31:0] CUR_SR_RESET = 32'h0000_00D3;
	localparam logic [31:0] SAVED_SR_RESET = 32'h0000_0000;
endpackage : seq_pkg

//--- sim/core_multicycle_sequencer_test.sv
// self-checking bench for the multicycle sequencer
`timescale 1ns/1ps
module core_multicycle_sequencer_test;
	import seq_pkg::*;
	localparam logic [1:0] CN = 2'h0, CS = 2'h1, CI = 2'h2;
	logic clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, op_start = 1'b0;
	logic op_byte = 1'b0, irq = 1'b0, abort_on = 1'b0;
	logic [3:0] reg_addr = 4'h0, cp_waits = 4'h0;
	logic [31:0] reg_wdata = 32'h0, op_data_addr = 32'h0, op_fetch_addr = 32'h0, op_vector = 32'h0;
	logic [31:0] op_cur_fetch_data_bus_addr = 32'h0, op_next_fetch_data_bus_addr = 32'h0;
	logic [31:0] op_store_data0 = 32'h0, op_store_data1 = 32'h0;
	logic [4:0] op_new_mode = 5'h0;
	logic [1:0] op_ret_kind = 2'h0, op_interlock = 2'h0, cp_kind = 2'h0;
	op_t op_code = op_preload;
	logic [31:0] reg_rdata, read_data, fetch_address_bus, data_address_bus, write_data;
	logic [31:0] dest_wr_data, link_wr_data;
	logic [1:0] coproc_decode_handshake, coproc_execute_handshake;
	logic data_abort, fetch_request_n, fetch_sequential, privileged_access_n, compressed_state_flag;
	logic data_request_n, data_sequential, data_write, data_byte, bus_lock_out, speculative_access_n;
	logic coproc_pass, late_abort_cancel, dest_wr_en, link_wr_en, busy, done, refused, abandoned;
	int n_mismatch = 0, checked = 0, cyc = 0;
	core_multicycle_sequencer u_core_multicycle_sequencer (.clk, .sys_rst, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .op_start, .op_code, .op_data_addr, .op_fetch_addr, .op_vector,
		.op_new_mode, .op_ret_kind, .op_cur_fetch_data_bus_addr, .op_next_fetch_data_bus_addr, .op_store_data0,
		.op_store_data1, .op_interlock, .op_byte, .irq, .read_data, .data_abort,
		.coproc_decode_handshake, .coproc_execute_handshake, .fetch_address_bus, .fetch_request_n,
		.fetch_sequential, .privileged_access_n, .compressed_state_flag, .data_address_bus,
		.data_request_n, .data_sequential, .data_write, .data_byte, .write_data, .bus_lock_out,
		.speculative_access_n, .coproc_pass, .late_abort_cancel, .dest_wr_en, .dest_wr_data,
		.link_wr_en, .link_wr_data, .busy, .done, .refused, .abandoned);
	far_side_model u_far_side_model (.clk, .data_request_n, .data_write, .data_address_bus,
		.coproc_pass, .abort_on, .cp_kind, .cp_waits, .read_data, .data_abort,
		.coproc_decode_handshake, .coproc_execute_handshake);
	always #25 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_mismatch++;
			wrap_up();
		end
	end
	task wrap_up;
		if (n_mismatch == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : wrap_up
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task nx;
		@(posedge clk);
		#1;
	endtask : nx
	// ends one settle step into cycle one of the operation
	task go(input op_t c);
		@(posedge clk);
		op_code <= c;
		op_start <= 1'b1;
		@(posedge clk);
		op_start <= 1'b0;
		#1;
	endtask : go
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	task rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, e);
	endtask : rd
	task t_regs;
		rd(REG_CUR_SR, CUR_SR_RESET);
		rd(REG_SAVED_SR, SAVED_SR_RESET);
		rd(4'h2, 32'h0);
		wr(REG_SAVED_SR, 32'hFF);
		rd(REG_SAVED_SR, SAVED_SR_RESET);
		wr(REG_CUR_SR, 32'h10);
		rd(REG_CUR_SR, 32'h10);
	endtask : t_regs
	task t_store;
		op_data_addr <= 32'h0000_1000;
		op_store_data0 <= 32'hA5A5_0001;
		op_store_data1 <= 32'h5A5A_0002;
		go(op_store_double);
		chk({data_request_n, data_sequential}, CN);
		chk({fetch_request_n, fetch_sequential}, CI);
		chk({busy, data_write}, 2'h3);
		nx();
		chk(data_address_bus, 32'h0000_1004);
		chk({fetch_request_n, fetch_sequential}, CS);
		chk(write_data, 32'hA5A5_0001);
		nx();
		chk(write_data, 32'h5A5A_0002);
		chk(done, 1'b1);
	endtask : t_store
	task t_swap(input logic [1:0] ilk, input logic ab);
		op_data_addr <= 32'h0000_0300;
		op_fetch_addr <= 32'h0000_2000;
		op_store_data0 <= 32'h1234_5678;
		op_interlock <= ilk;
		op_byte <= ilk[0];
		abort_on <= ab;
		go(op_swap);
		chk(bus_lock_out, 1'b1);
		chk(data_byte, ilk[0]);
		nx();
		chk({data_request_n, data_sequential, bus_lock_out}, 3'h1);
		chk({fetch_request_n, fetch_sequential}, ilk == 2'h0 ? CS : CI);
		nx();
		chk(write_data, 32'h1234_5678);
		chk({data_request_n, bus_lock_out}, 2'h2);
		chk({fetch_request_n, fetch_sequential}, ilk == 2'h1 ? CS : CI);
		if (ilk == 2'h1)
			chk(fetch_address_bus, 32'h0000_2000);
		// register write waits for the write-cycle abort answer
		nx();
		chk(dest_wr_en, !ab);
		if (!ab)
			chk(dest_wr_data, ilk[0] ? 32'h0000_00FF : 32'hFFFF_FCFF);
		chk({fetch_request_n, fetch_sequential, done}, ilk == 2'h2 ? 3'h2 : 3'h5);
		if (ilk == 2'h2) begin
			nx();
			chk(done, 1'b1);
		end
		abort_on <= 1'b0;
	endtask : t_swap
	task t_preload;
		op_data_addr <= 32'h0000_4440;
		go(op_preload);
		chk(data_address_bus, 32'h0000_4440);
		chk({data_request_n, data_sequential, speculative_access_n}, 3'h4);
		chk({fetch_request_n, fetch_sequential, done}, 3'h3);
	endtask : t_preload
	task t_entry;
		wr(REG_CTRL, 32'h1);
		op_vector <= 32'h0000_0018;
		op_new_mode <= 5'h11;
		op_cur_fetch_data_bus_addr <= 32'h0000_0100;
		op_next_fetch_data_bus_addr <= 32'h0000_0104;
		for (int k = 0; k < 4; k++) begin
			op_ret_kind <= 2'(k);
			go(op_exception);
			chk(fetch_address_bus, 32'h0000_0018);
			chk({privileged_access_n, compressed_state_flag, data_request_n}, 3'h5);
			nx();
			chk(link_wr_en, 1'b1);
			chk(link_wr_data, k[0] ? 32'h0000_0104 : 32'h0000_0100);
			nx();
			chk(fetch_address_bus, 32'h0000_0020);
			nx();
			chk(done, 1'b1);
			rd(REG_SAVED_SR, 32'h11);
		end
		rd(REG_CUR_SR, 32'h11);
		rd(REG_CTRL, 32'h0);
	endtask : t_entry
	task t_coproc(input logic [1:0] kind, input logic [3:0] waits);
		cp_kind <= kind;
		cp_waits <= waits;
		go(op_coproc);
		for (int i = 0; i <= int'(waits) && kind == HS_WAIT; i++) begin
			chk({coproc_pass, fetch_request_n, fetch_sequential}, 3'h6);
			nx();
		end
		chk({coproc_pass, late_abort_cancel, data_request_n}, 3'h5);
		chk({fetch_request_n, fetch_sequential, done}, 3'h3);
	endtask : t_coproc
	task t_refuse;
		cp_kind <= HS_ABSENT;
		go(op_coproc);
		chk({refused, coproc_pass}, 2'h2);
		wr(REG_CTRL, 32'h1);
		cp_kind <= HS_LAST;
		go(op_coproc);
		chk({refused, coproc_pass}, 2'h2);
		go(op_swap);
		chk({refused, bus_lock_out}, 2'h2);
		wr(REG_CTRL, 32'h0);
		cp_kind <= HS_WAIT;
		cp_waits <= 4'h8;
		go(op_coproc);
		@(posedge clk);
		irq <= 1'b1;
		@(posedge clk);
		irq <= 1'b0;
		#1 chk({abandoned, coproc_pass}, 2'h2);
		nx();
	endtask : t_refuse
	initial begin
		repeat (16) @(posedge clk);
		sys_rst <= 1'b0;
		t_regs();
		t_store();
		for (int j = 0; j < 3; j++)
			t_swap(2'(j), 1'b0);
		t_swap(2'h0, 1'b1);
		rd(REG_STATUS, 32'h2);
		wr(REG_STATUS, 32'h2);
		rd(REG_STATUS, 32'h0);
		t_preload();
		t_entry();
		t_coproc(HS_LAST, 4'h0);
		t_coproc(HS_WAIT, 4'h0);
		t_coproc(HS_WAIT, 4'h3);
		t_refuse();
		rd(REG_STATUS, 32'h4);
		wrap_up();
	end
endmodule : core_multicycle_sequencer_test

//--- sim/far_side_model.sv
// memory system and coprocessor model facing the sequencer
`timescale 1ns/1ps
module far_side_model
	import seq_pkg::*;
(
	input wire logic clk,
	input wire logic data_request_n,
	input wire logic data_write,
	input wire logic [31:0] data_address_bus,
	input wire logic coproc_pass,
	input wire logic abort_on,
	input wire logic [1:0] cp_kind,
	input wire logic [3:0] cp_waits,
	output logic [31:0] read_data,
	output logic data_abort,
	output logic [1:0] coproc_decode_handshake,
	output logic [1:0] coproc_execute_handshake
);
	logic [3:0] left_ff;
	// an idle bus shows the inverse, so a stale word never passes
	always_ff @(posedge clk) begin
		if (!data_request_n && !data_write)
			read_data <= ~data_address_bus;
		else
			read_data <= ~read_data;
		data_abort <= abort_on && !data_request_n;
		left_ff <= coproc_pass ? left_ff - 4'h1 : cp_waits;
	end
	// absent, wait or final as the bench orders
	assign coproc_decode_handshake = cp_kind;
	// commits only once the wait count has run out
	assign coproc_execute_handshake = !coproc_pass ? HS_ABSENT :
		(left_ff == 4'h0) ? HS_LAST : HS_WAIT;
endmodule : far_side_model

//--- sim/seq_assertions.sv
// port-level checker for the multicycle sequencer
`timescale 1ns/1ps
module seq_checker
	import seq_pkg::*;
#(
	parameter int AW = 32,
	parameter int DW = 32
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic data_abort,
	input wire logic [AW-1:0] fetch_address_bus,
	input wire logic fetch_request_n,
	input wire logic fetch_sequential,
	input wire logic privileged_access_n,
	input wire logic compressed_state_flag,
	input wire logic [AW-1:0] data_address_bus,
	input wire logic data_request_n,
	input wire logic data_sequential,
	input wire logic data_write,
	input wire logic bus_lock_out,
	input wire logic speculative_access_n,
	input wire logic coproc_pass,
	input wire logic late_abort_cancel,
	input wire logic dest_wr_en,
	input wire logic link_wr_en,
	input wire logic done,
	input wire logic refused
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	lock_needs_request_a: assert property (bus_lock_out |-> !data_request_n && !data_sequential)
		else $error("lock without data request");
	swap_pair_a: assert property (bus_lock_out && !data_write |-> fetch_request_n ##1 bus_lock_out
		&& data_write && !data_request_n && $stable(data_address_bus) ##1 !bus_lock_out)
		else $error("swap cycle pair broken");
	swap_stall_a: assert property (bus_lock_out && data_write && fetch_request_n |=>
		data_request_n ##[0:1] !fetch_request_n && fetch_sequential)
		else $error("interlocked swap fetch wrong");
	swap_abort_a: assert property (dest_wr_en |-> !$past(data_abort))
		else $error("register written after abort");
	store_pair_a: assert property (!data_request_n && !data_sequential && data_write && !bus_lock_out
		|=> !data_request_n && data_sequential && data_address_bus == $past(data_address_bus) + WORD_STEP)
		else $error("double store second word wrong");
	preload_hint_a: assert property (!speculative_access_n |-> data_request_n && !fetch_request_n
		&& fetch_sequential && done)
		else $error("preload cycle wrong");
	entry_first_a: assert property (!fetch_request_n && !fetch_sequential |-> data_request_n
		&& privileged_access_n && !compressed_state_flag ##1 link_wr_en && fetch_sequential
		&& fetch_address_bus == $past(fetch_address_bus) + WORD_STEP)
		else $error("entry second cycle wrong");
	entry_third_a: assert property (!fetch_request_n && !fetch_sequential |-> ##2 !fetch_request_n
		&& fetch_sequential && fetch_address_bus == $past(fetch_address_bus, 2) + VEC_STEP2)
		else $error("entry third fetch wrong");
	coproc_idle_a: assert property (coproc_pass |-> data_request_n && !late_abort_cancel)
		else $error("coprocessor cycle drives data side");
	refusal_quiet_a: assert property (refused |-> !coproc_pass && data_request_n && !bus_lock_out)
		else $error("refused operation issued");
endmodule : seq_checker
bind core_multicycle_sequencer seq_checker #(.AW(AW), .DW(DW)) u_seq_checker (.clk, .sys_rst,
	.data_abort, .fetch_address_bus, .fetch_request_n, .fetch_sequential, .privileged_access_n,
	.compressed_state_flag, .data_address_bus, .data_request_n, .data_sequential, .data_write,
	.bus_lock_out, .speculative_access_n, .coproc_pass, .late_abort_cancel, .dest_wr_en,
	.link_wr_en, .done, .refused);
